/* File: inc/dgp_cfg.svh */
// offsets, field positions, reset values and timing counts of the dual pin control block
`ifndef DGP_CFG_SVH
`define DGP_CFG_SVH

// register byte offsets
`define DGP_OFF_EVT_SET 8'h80
`define DGP_OFF_EVT_CLR 8'h84
`define DGP_OFF_MSK_SET 8'h88
`define DGP_OFF_MSK_CLR 8'h8c
`define DGP_OFF_CTRL 8'hfc

// pin control field positions
`define DGP_B_IRQ_EN 31
`define DGP_B_INV 29
`define DGP_B_OE 28
`define DGP_B_VAL 24
`define DGP_A_IRQ_EN 23
`define DGP_A_INV 21
`define DGP_A_OE 20
`define DGP_A_VAL 16

// general-purpose event bit in the event and mask registers
`define DGP_GP_EVT_BIT 25

// reset values
`define DGP_CTRL_RST 32'h0000_0000
`define DGP_RD_IDLE 32'h0000_0000

// synchroniser depth in clock cycles
`define DGP_SYNC_STAGES 2

`endif

/* File: inc/dgp_pkg.sv */
// types shared by the dual pin control block
package dgp_pkg;

   // software-owned pin control fields
   typedef struct packed {
      logic b_irq_en;
      logic b_inv;
      logic b_oe;
      logic b_val;
      logic a_irq_en;
      logic a_inv;
      logic a_oe;
      logic a_val;
   } dgp_ctrl_s;

   // drive of one two-way pin
   typedef struct packed {
      logic out;
      logic oe;
   } dgp_pin_drv_s;

endpackage

/* File: hw/dgp_pin_sync.sv */
// two-flop pin synchroniser with level-change detection
`timescale 1ns/1ps
module dgp_pin_sync (
   // clock, reset and freeze
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   // raw pin level
   input wire logic pin,
   // synchronised level and change flag
   output logic lvl,
   output logic chg
);
   logic meta;
   logic prev;

   // meta feeds only the second flop
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         meta <= 1'b0;
         lvl <= 1'b0;
         prev <= 1'b0;
      end else if (ce) begin
         meta <= pin;
         lvl <= meta;
         prev <= lvl;
      end
   end

   // one change per transition: prev catches up on the next enabled edge
   assign chg = lvl ^ prev; // R13

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   a_sync_follows_pin: assert property ( // R13
      (ce && $stable(pin))[*3] |-> (lvl == pin))
      else $error("synchronised level does not follow a stable pin");

   a_change_matches_edge: assert property ( // R13
      ce |=> (chg == (lvl != $past(lvl))))
      else $error("change flag disagrees with level history");

endmodule // dgp_pin_sync

/* File: hw/dgp_gpio.sv */
// dual general-purpose pin control and status with a wishbone register port
//
// Notes on behaviour
// R1: with pin b change interrupt enable (bit 31) set, every level change on pin b raises the event.
// R2: with pin a change interrupt enable (bit 23) set, every level change on pin a raises the event.
// R3: the pin event sets a sticky status flag and drives the interrupt only where its mask allows.
// R4: pin b polarity invert (bit 29) inverts the logical sense of pin b.
// R5: pin a polarity invert (bit 21) inverts the logical sense of pin a.
// R6: pin b is driven while its output enable (bit 28) is set and left floating otherwise.
// R7: pin a is driven while its output enable (bit 20) is set and left floating otherwise.
// R8: reading pin b value (bit 24) returns the live logical input, not the stored drive.
// R9: writing pin b value stores the drive level, seen on the pin only while enabled.
// R10: reading pin a value (bit 16) returns the live logical input, not the stored drive.
// R11: writing pin a value stores the drive level, seen on the pin only while enabled.
// R12: bits 30, 27-25, 22, 19-17 and 15-0 of the pin control word read zero and ignore writes.
// R13: each pin is synchronised and a change of successive samples makes one event.
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ps
`include "dgp_cfg.svh"
module dgp_gpio (
   // clock, reset and freeze
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   // wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // pin a
   input wire logic aux_pin_a_in,
   output dgp_pkg::dgp_pin_drv_s aux_pin_a_drv,
   // pin b
   input wire logic aux_pin_b_in,
   output dgp_pkg::dgp_pin_drv_s aux_pin_b_drv,
   // interrupt request
   output logic gp_irq
);
   import dgp_pkg::*;

   // byte lane that carries a bit position is enabled
   function automatic logic lane_on(input logic [3:0] sel, input int pos);
      lane_on = sel[pos / 8];
   endfunction

   // bit written as one on an enabled byte lane
   function automatic logic one_on(input logic [3:0] sel, input logic [31:0] dat,
                                   input int pos);
      one_on = sel[pos / 8] & dat[pos];
   endfunction

   // register offset match on word address
   function automatic logic at_off(input logic [7:0] adr, input logic [7:0] off);
      at_off = (adr[7:2] == off[7:2]);
   endfunction

   dgp_ctrl_s ctrl;
   dgp_ctrl_s next_ctrl;

   // reset image of the control fields, each taken from its own bit of the reset word,
   // so the struct never depends on how its members happen to pack
   localparam logic [31:0] CTRL_RST_WORD = `DGP_CTRL_RST;
   localparam dgp_ctrl_s CTRL_RST = '{
      b_irq_en: CTRL_RST_WORD[`DGP_B_IRQ_EN],
      b_inv: CTRL_RST_WORD[`DGP_B_INV],
      b_oe: CTRL_RST_WORD[`DGP_B_OE],
      b_val: CTRL_RST_WORD[`DGP_B_VAL],
      a_irq_en: CTRL_RST_WORD[`DGP_A_IRQ_EN],
      a_inv: CTRL_RST_WORD[`DGP_A_INV],
      a_oe: CTRL_RST_WORD[`DGP_A_OE],
      a_val: CTRL_RST_WORD[`DGP_A_VAL]
   };
   logic gp_event;
   logic gp_mask;
   logic next_event;
   logic next_mask;

   wire logic a_lvl;
   wire logic a_chg;
   wire logic b_lvl;
   wire logic b_chg;

   // both pins pass through their own synchroniser
   dgp_pin_sync u_sync_a (
      .mclk(mclk),
      .rst(rst),
      .ce(ce),
      .pin(aux_pin_a_in),
      .lvl(a_lvl),
      .chg(a_chg)
   );

   dgp_pin_sync u_sync_b (
      .mclk(mclk),
      .rst(rst),
      .ce(ce),
      .pin(aux_pin_b_in),
      .lvl(b_lvl),
      .chg(b_chg)
   );

   // bus request decode; ack high blocks a second take of the same cycle
   wire logic req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire logic wr = req & wb_we_i;
   wire logic hit_ctrl = at_off(wb_adr_i, `DGP_OFF_CTRL);
   wire logic hit_evt_set = at_off(wb_adr_i, `DGP_OFF_EVT_SET);
   wire logic hit_evt_clr = at_off(wb_adr_i, `DGP_OFF_EVT_CLR);
   wire logic hit_msk_set = at_off(wb_adr_i, `DGP_OFF_MSK_SET);
   wire logic hit_msk_clr = at_off(wb_adr_i, `DGP_OFF_MSK_CLR);
   wire logic wr_ctrl = wr & hit_ctrl;

   // byte lanes 3 and 2 hold pin b and pin a fields; reserved bits never stored
   wire logic lane_b = lane_on(wb_sel_i, `DGP_B_VAL);
   wire logic lane_a = lane_on(wb_sel_i, `DGP_A_VAL);
   wire logic upd_b = wr_ctrl & lane_b;
   wire logic upd_a = wr_ctrl & lane_a;

   // next control fields
   assign next_ctrl.b_irq_en = upd_b ? wb_dat_i[`DGP_B_IRQ_EN] : ctrl.b_irq_en;
   assign next_ctrl.b_inv = upd_b ? wb_dat_i[`DGP_B_INV] : ctrl.b_inv; // R4
   assign next_ctrl.b_oe = upd_b ? wb_dat_i[`DGP_B_OE] : ctrl.b_oe; // R6
   assign next_ctrl.b_val = upd_b ? wb_dat_i[`DGP_B_VAL] : ctrl.b_val; // R9
   assign next_ctrl.a_irq_en = upd_a ? wb_dat_i[`DGP_A_IRQ_EN] : ctrl.a_irq_en;
   assign next_ctrl.a_inv = upd_a ? wb_dat_i[`DGP_A_INV] : ctrl.a_inv; // R5
   assign next_ctrl.a_oe = upd_a ? wb_dat_i[`DGP_A_OE] : ctrl.a_oe; // R7
   assign next_ctrl.a_val = upd_a ? wb_dat_i[`DGP_A_VAL] : ctrl.a_val; // R11

   // logical pin values seen through the polarity invert
   wire logic a_logic = a_lvl ^ ctrl.a_inv; // R5
   wire logic b_logic = b_lvl ^ ctrl.b_inv; // R4

   // change events; raw levels are compared so toggling invert makes no event
   wire logic pin_a_evt = a_chg & ctrl.a_irq_en; // R2
   wire logic pin_b_evt = b_chg & ctrl.b_irq_en; // R1
   wire logic pin_evt = pin_a_evt | pin_b_evt;

   // software set and clear of event and mask bits
   wire logic evt_sw_set = wr & hit_evt_set & one_on(wb_sel_i, wb_dat_i, `DGP_GP_EVT_BIT);
   wire logic evt_sw_clr = wr & hit_evt_clr & one_on(wb_sel_i, wb_dat_i, `DGP_GP_EVT_BIT);
   wire logic msk_sw_set = wr & hit_msk_set & one_on(wb_sel_i, wb_dat_i, `DGP_GP_EVT_BIT);
   wire logic msk_sw_clr = wr & hit_msk_clr & one_on(wb_sel_i, wb_dat_i, `DGP_GP_EVT_BIT);

   // a pin event in the clearing cycle survives: set wins over clear
   assign next_event = pin_evt | evt_sw_set | (gp_event & ~evt_sw_clr); // R3
   assign next_mask = msk_sw_set | (gp_mask & ~msk_sw_clr); // R3

   // read words; everything outside the named fields is zero
   logic [31:0] ctrl_word;
   logic [31:0] evt_word;
   logic [31:0] evt_masked_word;
   logic [31:0] msk_word;
   logic [31:0] rd_word;

   always_comb begin
      ctrl_word = `DGP_RD_IDLE; // R12
      ctrl_word[`DGP_B_IRQ_EN] = ctrl.b_irq_en;
      ctrl_word[`DGP_B_INV] = ctrl.b_inv;
      ctrl_word[`DGP_B_OE] = ctrl.b_oe;
      ctrl_word[`DGP_B_VAL] = b_logic; // R8
      ctrl_word[`DGP_A_IRQ_EN] = ctrl.a_irq_en;
      ctrl_word[`DGP_A_INV] = ctrl.a_inv;
      ctrl_word[`DGP_A_OE] = ctrl.a_oe;
      ctrl_word[`DGP_A_VAL] = a_logic; // R10
   end

   // the clear address reads the masked event, as a pending view
   always_comb begin
      evt_word = `DGP_RD_IDLE;
      evt_word[`DGP_GP_EVT_BIT] = gp_event;
      evt_masked_word = `DGP_RD_IDLE;
      evt_masked_word[`DGP_GP_EVT_BIT] = gp_event & gp_mask;
      msk_word = `DGP_RD_IDLE;
      msk_word[`DGP_GP_EVT_BIT] = gp_mask;
   end

   // unmapped offsets answer with zero data, never stall the bus
   assign rd_word = hit_ctrl ? ctrl_word :
                    hit_evt_set ? evt_word :
                    hit_evt_clr ? evt_masked_word :
                    (hit_msk_set | hit_msk_clr) ? msk_word :
                    `DGP_RD_IDLE;

   // bus answer one cycle after the request, held for one enabled cycle only
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= `DGP_RD_IDLE;
      end else if (ce) begin
         wb_ack_o <= req;
         if (req & ~wb_we_i) begin
            wb_dat_o <= rd_word; // R8 R10 R12
         end
      end
   end

   // control and status state; ce low freezes all of it
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrl <= CTRL_RST;
         gp_event <= 1'b0;
         gp_mask <= 1'b0;
      end else if (ce) begin
         ctrl <= next_ctrl;
         gp_event <= next_event;
         gp_mask <= next_mask;
      end
   end

   // pin drivers: stored value goes out through the invert; oe low means floating
   assign aux_pin_a_drv.oe = ctrl.a_oe; // R7
   assign aux_pin_a_drv.out = ctrl.a_val ^ ctrl.a_inv; // R11
   assign aux_pin_b_drv.oe = ctrl.b_oe; // R6
   assign aux_pin_b_drv.out = ctrl.b_val ^ ctrl.b_inv; // R9

   // interrupt only from the sticky flag and the mask, both flops
   assign gp_irq = gp_event & gp_mask; // R3

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   // a taken control write and a taken control read
   sequence s_ctrl_wr_a;
      ce && wr_ctrl && lane_a;
   endsequence

   sequence s_ctrl_wr_b;
      ce && wr_ctrl && lane_b;
   endsequence

   sequence s_ctrl_rd;
      ce && req && !wb_we_i && hit_ctrl;
   endsequence

   a_ack_one_cycle: assert property (
      ce && req |=> wb_ack_o ##1 (!wb_ack_o || !ce))
      else $error("bus answer is not a single cycle pulse");

   a_pin_b_enable: assert property ( // R6
      s_ctrl_wr_b |=> (aux_pin_b_drv.oe == $past(wb_dat_i[`DGP_B_OE])))
      else $error("pin b output enable does not follow the write");

   a_pin_a_enable: assert property ( // R7
      s_ctrl_wr_a |=> (aux_pin_a_drv.oe == $past(wb_dat_i[`DGP_A_OE])))
      else $error("pin a output enable does not follow the write");

   a_pin_b_drive: assert property ( // R9
      s_ctrl_wr_b |=>
         (aux_pin_b_drv.out == ($past(wb_dat_i[`DGP_B_VAL]) ^ $past(wb_dat_i[`DGP_B_INV]))))
      else $error("pin b drive level does not follow the write");

   a_pin_a_drive: assert property ( // R11
      s_ctrl_wr_a |=>
         (aux_pin_a_drv.out == ($past(wb_dat_i[`DGP_A_VAL]) ^ $past(wb_dat_i[`DGP_A_INV]))))
      else $error("pin a drive level does not follow the write");

   a_read_b_live: assert property ( // R8
      s_ctrl_rd |=> (wb_dat_o[`DGP_B_VAL] == ($past(b_lvl) ^ $past(ctrl.b_inv))))
      else $error("pin b value read is not the live input");

   a_read_a_live: assert property ( // R10
      s_ctrl_rd |=> (wb_dat_o[`DGP_A_VAL] == ($past(a_lvl) ^ $past(ctrl.a_inv))))
      else $error("pin a value read is not the live input");

   a_invert_b_read: assert property ( // R4
      s_ctrl_rd ##0 ctrl.b_inv |=> (wb_dat_o[`DGP_B_VAL] != $past(b_lvl)))
      else $error("pin b invert does not flip the read value");

   a_invert_a_read: assert property ( // R5
      s_ctrl_rd ##0 ctrl.a_inv |=> (wb_dat_o[`DGP_A_VAL] != $past(a_lvl)))
      else $error("pin a invert does not flip the read value");

   a_reserved_zero: assert property ( // R12
      s_ctrl_rd |=> ((wb_dat_o & 32'h4e4e_ffff) == 32'h0000_0000))
      else $error("reserved pin control bits read nonzero");

   a_change_b_event: assert property ( // R1
      ce && b_chg && ctrl.b_irq_en |=> gp_event)
      else $error("pin b change did not raise the event");

   a_change_a_event: assert property ( // R2
      ce && a_chg && ctrl.a_irq_en |=> gp_event)
      else $error("pin a change did not raise the event");

   a_irq_needs_cause: assert property ( // R3
      !gp_irq ##1 gp_irq |-> $past(pin_evt || evt_sw_set || msk_sw_set))
      else $error("interrupt rose with no event or mask set");

   a_event_sticky: assert property ( // R3
      ce && gp_event && !evt_sw_clr |=> gp_event)
      else $error("event flag dropped without a clear");

   a_event_needs_cause: assert property ( // R1 R2
      ce && !gp_event && !pin_evt && !evt_sw_set |=> !gp_event)
      else $error("event flag set without a pin change or software set");

   // ce low must hold the control, event and mask flops, the bus answer included
   a_freeze_state: assert property (
      !ce |=> ($stable(ctrl) && $stable(gp_event) && $stable(gp_mask) && $stable(wb_ack_o)))
      else $error("state moved while the clock enable was low");

   a_ack_needs_req: assert property (
      !wb_ack_o ##1 wb_ack_o |-> $past(ce && req))
      else $error("bus answer without a taken request");

   a_irq_event_masked: assert property ( // R3
      ce && pin_evt && gp_mask && !msk_sw_clr |=> gp_irq)
      else $error("masked-in event did not reach the interrupt");

endmodule // dgp_gpio

/* File: bench/dgp_board.sv */
// board logic model that drives each pin the block releases, when its ext_oe bit is set; otherwise the pin floats
`timescale 1ns/1ps
module dgp_board (
   // clock
   input wire logic mclk,
   // block pin drives
   input wire dgp_pkg::dgp_pin_drv_s drv_a,
   input wire dgp_pkg::dgp_pin_drv_s drv_b,
   // board drive request, index 0 = pin a
   input wire logic [1:0] ext_oe,
   input wire logic [1:0] ext_val,
   // resolved pin levels
   output logic pin_a,
   output logic pin_b
);
   import dgp_pkg::*;
   logic wobble = 1'b0;

   // an undriven pin has no pull, so it shows a level that flips every cycle
   always_ff @(posedge mclk) begin
      wobble <= ~wobble;
   end

   // the board backs off while the block drives, so the lines never fight
   assign pin_a = drv_a.oe ? drv_a.out : (ext_oe[0] ? ext_val[0] : wobble);
   assign pin_b = drv_b.oe ? drv_b.out : (ext_oe[1] ? ext_val[1] : wobble);
endmodule // dgp_board

/* File: bench/dgp_gpio_bench.sv */
// self-checking bench for the dual pin control block
`timescale 1ns/1ps
`include "dgp_cfg.svh"
module dual_gpio_pin_control_bench;
   import dgp_pkg::*;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0000_0000, rdat, dat_o;
   logic ack, pin_a, pin_b, gp_irq;
   logic [1:0] ext_oe = 2'b11, ext_val = 2'b00;
   logic ce = 1'b1;
   dgp_pin_drv_s drv_a, drv_b;
   int n_mismatch = 0, n_checks = 0;

   // 50 MHz clock
   initial begin
      forever #10 mclk = ~mclk;
   end

   dgp_gpio dut (.mclk(mclk), .rst(rst), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_sel_i(4'hf), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .aux_pin_a_in(pin_a), .aux_pin_a_drv(drv_a), .aux_pin_b_in(pin_b),
      .aux_pin_b_drv(drv_b), .gp_irq(gp_irq));

   dgp_board board (.mclk(mclk), .drv_a(drv_a), .drv_b(drv_b), .ext_oe(ext_oe),
      .ext_val(ext_val), .pin_a(pin_a), .pin_b(pin_b));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   // one classic cycle; the request holds until ack is seen at a rising edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      n = 0;
      @(posedge mclk);
      while (ack !== 1'b1 && n < 50) begin
         @(posedge mclk);
         n++;
      end
      if (n >= 50) n_mismatch++;
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge mclk);
   endtask

   // pins need two sync stages, the event flag one more
   task automatic settle();
      repeat (4) @(posedge mclk);
   endtask

   task automatic t_reset();
      wb(1'b0, `DGP_OFF_CTRL, 32'h0000_0000);
      check(rdat, 32'h0000_0000);
      check(32'({drv_b.oe, drv_a.oe}), 32'h0000_0000);
      wb(1'b0, 8'h40, 32'h0000_0000);
      check(rdat, 32'h0000_0000);
   endtask

   // all ones: reserved bits stay zero, driven level is the inverted stored value
   task automatic t_reserved();
      wb(1'b1, `DGP_OFF_CTRL, 32'hffff_ffff);
      check(32'({drv_b, drv_a}), 32'h0000_0005);
      settle();
      wb(1'b0, `DGP_OFF_CTRL, 32'h0000_0000);
      check(rdat, 32'hb1b1_0000);
   endtask

   task automatic t_drive();
      wb(1'b1, `DGP_OFF_CTRL, 32'h1111_0000);
      check(32'({drv_b, drv_a}), 32'h0000_000f);
      settle();
      wb(1'b0, `DGP_OFF_CTRL, 32'h0000_0000);
      check(rdat, 32'h1111_0000);
      wb(1'b1, `DGP_OFF_CTRL, 32'h0101_0000);
      check(32'({drv_b.oe, drv_a.oe}), 32'h0000_0000);
      settle();
      wb(1'b0, `DGP_OFF_CTRL, 32'h0000_0000);
      check(rdat, 32'h0000_0000);
      wb(1'b1, `DGP_OFF_CTRL, 32'h2020_0000);
      wb(1'b0, `DGP_OFF_CTRL, 32'h0000_0000);
      check(rdat, 32'h2121_0000);
   endtask

   task automatic t_event();
      wb(1'b1, `DGP_OFF_CTRL, 32'h8000_0000);
      settle();
      wb(1'b1, `DGP_OFF_EVT_CLR, 32'h0200_0000);
      wb(1'b1, `DGP_OFF_MSK_SET, 32'h0200_0000);
      check(32'(gp_irq), 32'h0000_0000);
      ext_val[1] <= 1'b1;
      settle();
      check(32'(gp_irq), 32'h0000_0001);
      wb(1'b0, `DGP_OFF_EVT_CLR, 32'h0000_0000);
      check(rdat, 32'h0200_0000);
      wb(1'b1, `DGP_OFF_EVT_CLR, 32'h0200_0000);
      check(32'(gp_irq), 32'h0000_0000);
      // pin a change with its enable off must stay silent
      ext_val[0] <= 1'b1;
      settle();
      check(32'(gp_irq), 32'h0000_0000);
      wb(1'b1, `DGP_OFF_CTRL, 32'h0080_0000);
      ext_val[0] <= 1'b0;
      settle();
      check(32'(gp_irq), 32'h0000_0001);
      wb(1'b1, `DGP_OFF_MSK_CLR, 32'h0200_0000);
      check(32'(gp_irq), 32'h0000_0000);
      wb(1'b0, `DGP_OFF_EVT_SET, 32'h0000_0000);
      check(rdat, 32'h0200_0000);
   endtask

   // clock enable low holds a pin change back; it lands once the enable returns
   task automatic t_freeze();
      wb(1'b1, `DGP_OFF_CTRL, 32'h8000_0000);
      wb(1'b1, `DGP_OFF_EVT_CLR, 32'h0200_0000);
      wb(1'b1, `DGP_OFF_MSK_SET, 32'h0200_0000);
      check(32'(gp_irq), 32'h0000_0000);
      ce <= 1'b0;
      ext_val[1] <= 1'b0;
      repeat (6) @(posedge mclk);
      check(32'(gp_irq), 32'h0000_0000);
      ce <= 1'b1;
      settle();
      check(32'(gp_irq), 32'h0000_0001);
   endtask

   task automatic report_and_stop();
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // watchdog far beyond the hundred or so cycles the run needs
   initial begin
      #200_000;
      n_mismatch++;
      report_and_stop();
   end

   initial begin
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      t_reset();
      t_reserved();
      t_drive();
      t_event();
      t_freeze();
      report_and_stop();
   end
endmodule // dual_gpio_pin_control_bench
